// ==== dv/rif_ahb_host.sv ====
// ahb-lite host model that issues the bench's single word transfers
module rif_ahb_host (
   // clock, reset and bench request
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_go,
   input wire logic i_wr,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   // ahb-lite master side
   input wire logic i_hready,
   input wire logic [31:0] i_hrdata,
   output logic [31:0] o_haddr = 32'h0,
   output logic [1:0] o_htrans = 2'h0,
   output logic o_hwrite = 1'b0,
   output logic [2:0] o_hsize = 3'h2,
   output logic [31:0] o_hwdata = 32'h0,
   // completion pulse and read word
   output logic o_done = 1'b0,
   output logic [31:0] o_rdata = 32'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph_q = 2'h0;
   // each phase stands until hready is seen high at a rising edge
   always @(posedge i_clk) begin
      o_done <= 1'b0;
      if (i_rst) begin
         ph_q <= 2'h0;
         o_htrans <= 2'h0;
      end else if (ph_q == 2'h0 && i_go === 1'b1) begin
         ph_q <= 2'h1;
         o_htrans <= 2'h2;
         o_haddr <= {24'h0, i_addr};
         o_hwrite <= i_wr;
      end else if (ph_q == 2'h1 && i_hready) begin
         ph_q <= 2'h2;
         o_htrans <= 2'h0;
         o_hwdata <= {24'h0, i_wdata};
      end else if (ph_q == 2'h2 && i_hready) begin
         ph_q <= 2'h0;
         o_done <= 1'b1;
         o_rdata <= i_hrdata;
         // released data lines flip so a stale word never looks valid
         o_hwdata <= ~o_hwdata;
      end
   end
endmodule

// ==== dv/tb_rif_irq.sv ====
// self-checking bench for the radio irq and fifo flag block
`include "rif_defs.svh"
module tb_rif_irq;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] a_cfg = `RIF_ADDR_DEPTH_CFG;
   localparam logic [7:0] a_map = `RIF_ADDR_SRC_MAP;
   localparam logic [7:0] a_fl = `RIF_ADDR_FLAGS;
   localparam logic [7:0] a_lvl = `RIF_ADDR_LEVEL;
   localparam logic [7:0] a_st = `RIF_ADDR_STATE;
   logic i_clk = 1'b0, i_rst = 1'b1, go = 1'b0, wr = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, str = 8'h00;
   logic [31:0] haddr, hwdata, hrdata, rdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [6:0] cnt = 7'h00, depth, level;
   // {addr match, bit clock, byte written, crc, payload, sync}
   logic [5:0] ev = 6'h00;
   logic filt = 1'b0, last = 1'b0, ovr = 1'b0, lock = 1'b0;
   logic hwrite, hready, hresp, done, irq0, irq1;
   logic lock_pin, tx_start, fill_en, restart;
   int failures = 0, check_count = 0, restarts = 0;
   // entries: radio state, source map, event index, filter, pin
   logic [23:0] tab [10] = '{24'h000000, 24'h000041, 24'h014030,
      24'h05c000, 24'h020010, 24'h020021, 24'h02c000, 24'h02c052,
      24'h080041, 24'h008000};
   always #2.5 i_clk = ~i_clk;
   always @(posedge i_clk) if (restart === 1'b1) restarts <= restarts + 1;
   rif_ahb_host u_host (.i_clk(i_clk), .i_rst(i_rst), .i_go(go),
      .i_wr(wr), .i_addr(addr), .i_wdata(wdata), .i_hready(hready),
      .i_hrdata(hrdata), .o_haddr(haddr), .o_htrans(htrans),
      .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata),
      .o_done(done), .o_rdata(rdata));
   rif_irq u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(1'b1),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
      .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
      .i_fifo_count(cnt), .i_sync_det(ev[0]), .i_addr_match(ev[5]),
      .i_addr_filt_en(filt), .i_payload_ready(ev[1]), .i_crc_ok(ev[2]),
      .i_byte_written(ev[3]), .i_bit_clock(ev[4]), .i_last_bit_out(last),
      .i_overrun(ovr), .i_strength(str), .i_pll_lock(lock),
      .o_irq0(irq0), .o_irq1(irq1), .o_lock_pin(lock_pin),
      .o_tx_start(tx_start), .o_fill_en(fill_en), .o_restart(restart),
      .o_fifo_depth(depth), .o_fifo_level(level));
   ////////////////////////////////////////////////////////////////////
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // one word transfer through the host; the bound cuts a hung bus
   task automatic xfer(logic w, logic [7:0] a, logic [7:0] d);
      int n = 0;
      @(posedge i_clk);
      go <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= d;
      @(posedge i_clk);
      go <= 1'b0;
      while (done !== 1'b1 && n < 20) begin
         @(posedge i_clk);
         n++;
      end
      if (n == 20) begin
         failures++;
         finish_test();
      end
   endtask
   task automatic get(string name, logic [7:0] a, logic [31:0] exp);
      xfer(1'b0, a, 8'h00);
      chk(name, rdata, exp);
   endtask
   // levels change at an edge; the next edge leaves outputs settled
   task automatic drv(logic [6:0] c, logic [5:0] e, logic f);
      @(posedge i_clk);
      cnt <= c;
      ev <= e;
      filt <= f;
      @(posedge i_clk);
   endtask
   // k: 0 sync, 1 last bit out, 2 overrun, 3 pll lock
   task automatic pulse(int k);
      @(posedge i_clk);
      {lock, ovr, last, ev[0]} <= 4'h1 << k;
      @(posedge i_clk);
      {lock, ovr, last, ev[0]} <= 4'h0;
      @(posedge i_clk);
   endtask
   initial begin
      int base;
      logic [23:0] t;
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      get("depth_cfg", a_cfg, 32'h0f);
      get("src_map", a_map, 32'h00);
      get("flags", a_fl, 32'h01);
      get("level_reg", a_lvl, 32'h00);
      xfer(1'b1, 8'h50, 8'hff);
      get("unmapped", 8'h50, 32'h00);
      chk("hresp", hresp, 1'b0);
      chk("depth", depth, 7'h10);
      chk("level", level, 7'h10);
      $display("test reset values done");
      foreach (tab[k]) begin
         t = tab[k];
         xfer(1'b1, a_st, t[23:16]);
         xfer(1'b1, a_map, t[15:8]);
         drv(7'h00, 6'h01 << t[7:4], t[1]);
         chk("irq_on", t[0] ? irq1 : irq0, 1'b1);
         drv(7'h00, ~(6'h01 << t[7:4]), t[1]);
         chk("irq_off", t[0] ? irq1 : irq0, 1'b0);
      end
      xfer(1'b1, a_st, 8'h01);
      xfer(1'b1, a_map, 8'h00);
      drv(7'h10, 6'h3f, 1'b0);
      chk("irq_none", {irq0, irq1}, 2'b00);
      $display("test source routing done");
      xfer(1'b1, a_st, 8'h05);
      xfer(1'b1, a_map, 8'hb0);
      drv(7'h00, 6'h00, 1'b0);
      chk("irq_empty", {irq0, irq1}, 2'b00);
      get("src_map", a_map, 32'hb0);
      drv(7'h0f, 6'h00, 1'b0);
      chk("irq_15", {irq0, irq1}, 2'b10);
      get("src_map", a_map, 32'hb1);
      drv(7'h10, 6'h00, 1'b0);
      chk("irq_16", {irq0, irq1}, 2'b11);
      xfer(1'b1, a_map, 8'h90);
      chk("irq_full", irq1, 1'b1);
      for (int d = 0; d < 4; d++) begin
         xfer(1'b1, a_cfg, {d[1:0], 6'h05});
         chk("depth", depth, 16 * (d + 1));
         chk("level", level, 7'h06);
         drv(7'(16 * (d + 1) - 1), 6'h00, 1'b0);
         get("src_map", a_map, 32'h91);
         drv(7'(16 * (d + 1)), 6'h00, 1'b0);
         get("src_map", a_map, 32'h93);
      end
      xfer(1'b1, a_cfg, 8'h0f);
      $display("test fifo flags done");
      get("flags", a_fl, 32'h41);
      xfer(1'b1, a_fl, 8'h41);
      get("flags", a_fl, 32'h01);
      xfer(1'b1, a_st, 8'h09);
      xfer(1'b1, a_map, 8'h00);
      drv(7'h0f, 6'h00, 1'b0);
      chk("tx_15", {tx_start, irq0, irq1}, 3'b000);
      drv(7'h10, 6'h00, 1'b0);
      chk("tx_16", {tx_start, irq0, irq1}, 3'b111);
      xfer(1'b1, a_map, 8'h0c);
      drv(7'h00, 6'h00, 1'b0);
      chk("tx_empty", {tx_start, irq0, irq1}, 3'b000);
      pulse(1);
      drv(7'h01, 6'h00, 1'b0);
      chk("tx_one", {tx_start, irq0, irq1}, 3'b111);
      get("flags", a_fl, 32'h21);
      $display("test transmit done");
      xfer(1'b1, a_st, 8'h01);
      get("flags", a_fl, 32'h01);
      chk("fill_idle", fill_en, 1'b0);
      pulse(0);
      get("flags", a_fl, 32'h41);
      chk("fill_auto", fill_en, 1'b1);
      xfer(1'b1, a_fl, 8'h41);
      get("flags", a_fl, 32'h01);
      chk("fill_rearm", fill_en, 1'b0);
      pulse(2);
      get("flags", a_fl, 32'h11);
      base = restarts;
      xfer(1'b1, a_fl, 8'h11);
      repeat (3) @(posedge i_clk);
      chk("restarts", restarts - base, 1);
      get("flags", a_fl, 32'h01);
      xfer(1'b1, a_fl, 8'hc1);
      chk("fill_manual", fill_en, 1'b1);
      xfer(1'b1, a_fl, 8'h81);
      chk("fill_stop", fill_en, 1'b0);
      $display("test fill and overrun done");
      xfer(1'b1, a_lvl, 8'h40);
      get("level_reg", a_lvl, 32'h40);
      @(posedge i_clk);
      str <= 8'h41;
      get("flags", a_fl, 32'h81);
      str <= 8'h40;
      xfer(1'b1, a_fl, 8'h89);
      get("flags", a_fl, 32'h89);
      str <= 8'h41;
      get("flags", a_fl, 32'h8d);
      xfer(1'b1, a_st, 8'h00);
      xfer(1'b1, a_map, 8'h40);
      chk("irq_str", irq0, 1'b1);
      str <= 8'h00;
      get("flags", a_fl, 32'h8d);
      chk("irq_str_off", irq0, 1'b0);
      xfer(1'b1, a_fl, 8'h8d);
      get("flags", a_fl, 32'h89);
      pulse(3);
      get("flags", a_fl, 32'h8b);
      chk("lock_pin", lock_pin, 1'b1);
      xfer(1'b1, a_fl, 8'h8b);
      get("flags", a_fl, 32'h89);
      chk("lock_pin", lock_pin, 1'b0);
      xfer(1'b1, a_fl, 8'h88);
      chk("lock_pin", lock_pin, 1'b1);
      $display("test strength and lock done");
      finish_test();
   end
endmodule

// ==== logic/rif_defs.svh ====
// register offsets, field positions, reset values for the radio irq block
`ifndef RIF_DEFS_SVH
`define RIF_DEFS_SVH
// register indexes; the byte address on the bus is four times the index
`define RIF_IDX_DEPTH_CFG 8'h0c
`define RIF_IDX_SRC_MAP 8'h0d
`define RIF_IDX_FLAGS 8'h0e
`define RIF_IDX_LEVEL 8'h0f
`define RIF_ADDR_DEPTH_CFG 8'h30
`define RIF_ADDR_SRC_MAP 8'h34
`define RIF_ADDR_FLAGS 8'h38
`define RIF_ADDR_LEVEL 8'h3c
`define RIF_ADDR_STATE 8'h40
`define RIF_RST_DEPTH_CFG 8'h0f
`define RIF_RST_SRC_MAP 8'h00
`define RIF_RST_FLAGS 8'h01
`define RIF_RST_LEVEL 8'h00
`define RIF_RST_STATE 8'h00
`define RIF_BIT_FILL_METHOD 7
`define RIF_BIT_FILL 6
`define RIF_BIT_TX_DONE 5
`define RIF_BIT_OVERRUN 4
`define RIF_BIT_STR_EN 3
`define RIF_BIT_STR_FLAG 2
`define RIF_BIT_LOCK 1
`define RIF_BIT_LOCK_EN 0
`endif

// ==== logic/rif_irq.sv ====
// radio interrupt source selection, fifo flags and status register block
//
// The implementer's own choice: the AHB-Lite slave port.
module rif_irq #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // data path events, same clock
   input wire logic [6:0] i_fifo_count,
   input wire logic i_sync_det,
   input wire logic i_addr_match,
   input wire logic i_addr_filt_en,
   input wire logic i_payload_ready,
   input wire logic i_crc_ok,
   input wire logic i_byte_written,
   input wire logic i_bit_clock,
   input wire logic i_last_bit_out,
   input wire logic i_overrun,
   input wire logic [7:0] i_strength,
   input wire logic i_pll_lock,
   // interrupt and control outputs
   output logic o_irq0,
   output logic o_irq1,
   output logic o_lock_pin,
   output logic o_tx_start,
   output logic o_fill_en,
   output logic o_restart,
   output logic [6:0] o_fifo_depth,
   output logic [6:0] o_fifo_level
);
`include "rif_defs.svh"

   logic [7:0] depth_cfg_q;
   logic [7:0] src_map_q;
   logic [7:0] flags_q;
   logic [7:0] level_q;
   logic [7:0] state_q;
   rif_pkg::rif_bus_type bus_q;
   logic wr_q;
   logic [ADDR_W-1:0] addr_q;
   logic [31:0] rdata_q;
   logic [6:0] depth;
   logic [6:0] thresh;
   logic full;
   logic not_empty;
   logic over_thresh;
   logic str_event;
   rif_pkg::rif_mode_type mode;
   rif_pkg::rif_radio_type radio;
   logic wr_now;
   logic [7:0] wd;

   ////////////////////////////////////////////////////////////////////////
   // decode helpers
   function automatic rif_pkg::rif_mode_type mode_of(input logic [1:0] m);
      if (m == 2'h0) begin
         return rif_pkg::RIF_CONT;
      end else if (m == 2'h1) begin
         return rif_pkg::RIF_BUFF;
      end
      return rif_pkg::RIF_PKT;
   endfunction

   function automatic rif_pkg::rif_radio_type radio_of(input logic [1:0] r);
      if (r == 2'h2) begin
         return rif_pkg::RIF_TX;
      end else if (r == 2'h1) begin
         return rif_pkg::RIF_STBY;
      end
      return rif_pkg::RIF_RX;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // derived fifo figures
   // depth in 16-byte steps, 7 bits so 64 fits
   assign depth = {1'b0, depth_cfg_q[7:6], 4'h0} + 7'h10;
   assign thresh = {1'b0, depth_cfg_q[5:0]} + 7'h01;
   assign full = (i_fifo_count >= depth);
   assign not_empty = (i_fifo_count != 7'h00);
   assign over_thresh = (i_fifo_count >= thresh);
   // source gated by the enable bit; reset leaves it off
   assign str_event = flags_q[`RIF_BIT_STR_EN] &
      (i_strength > level_q);
   assign mode = mode_of(state_q[1:0]);
   assign radio = radio_of(state_q[3:2]);
   assign o_fifo_depth = depth;
   assign o_fifo_level = thresh;

   ////////////////////////////////////////////////////////////////////////
   // interrupt pin routing, pure levels so a mode change shows at once
   always_comb begin
      o_irq0 = 1'b0;
      o_irq1 = 1'b0;
      if (radio == rif_pkg::RIF_TX) begin
         // start selector also picks pin 0
         o_irq0 = src_map_q[3] ? not_empty : over_thresh;
         if (mode == rif_pkg::RIF_CONT) begin
            o_irq1 = i_bit_clock;
         end else begin
            o_irq1 = src_map_q[2] ? flags_q[`RIF_BIT_TX_DONE] : full;
         end
      end else begin
         // fifo sources stay live in standby too
         case (mode)
            rif_pkg::RIF_CONT: begin
               o_irq0 = (src_map_q[7:6] == 2'h1) ? str_event
                  : i_sync_det;
               o_irq1 = i_bit_clock;
            end
            rif_pkg::RIF_BUFF: begin
               case (src_map_q[7:6])
                  2'h0: o_irq0 = 1'b0;
                  2'h1: o_irq0 = i_byte_written;
                  2'h2: o_irq0 = not_empty;
                  default: o_irq0 = i_sync_det;
               endcase
               case (src_map_q[5:4])
                  2'h0: o_irq1 = 1'b0;
                  2'h1: o_irq1 = full;
                  2'h2: o_irq1 = str_event;
                  default: o_irq1 = over_thresh;
               endcase
            end
            default: begin
               case (src_map_q[7:6])
                  2'h0: o_irq0 = i_payload_ready;
                  2'h1: o_irq0 = i_byte_written;
                  2'h2: o_irq0 = not_empty;
                  default: o_irq0 = i_addr_filt_en ? i_addr_match
                     : i_sync_det;
               endcase
               case (src_map_q[5:4])
                  2'h0: o_irq1 = i_crc_ok;
                  2'h1: o_irq1 = full;
                  2'h2: o_irq1 = str_event;
                  default: o_irq1 = over_thresh;
               endcase
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit start, fill enable and lock pin
   always_comb begin
      o_tx_start = (radio == rif_pkg::RIF_TX) &
         (src_map_q[3] ? not_empty : over_thresh);
      // fill bit gates filling only in buffered mode; other modes load unconditionally
      o_fill_en = (mode != rif_pkg::RIF_BUFF) |
         flags_q[`RIF_BIT_FILL];
      o_lock_pin = flags_q[`RIF_BIT_LOCK_EN] ?
         flags_q[`RIF_BIT_LOCK] : 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // ahb-lite address phase capture; always zero wait states
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         bus_q <= rif_pkg::RIF_IDLE;
         wr_q <= 1'b0;
         addr_q <= '0;
      end else if (i_hready) begin
         if (i_hsel && i_htrans[1]) begin
            bus_q <= rif_pkg::RIF_DATA;
            wr_q <= i_hwrite;
            addr_q <= i_haddr[ADDR_W-1:0];
         end else begin
            bus_q <= rif_pkg::RIF_IDLE;
            wr_q <= 1'b0;
         end
      end
   end

   assign wr_now = (bus_q == rif_pkg::RIF_DATA) && wr_q;
   assign wd = i_hwdata[7:0];
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;
   assign o_hrdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // read/write configuration registers; source map bits 1:0 read full and not-empty, state bits 7:4 read zero
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         depth_cfg_q <= `RIF_RST_DEPTH_CFG;
         src_map_q <= `RIF_RST_SRC_MAP;
         level_q <= `RIF_RST_LEVEL;
         state_q <= `RIF_RST_STATE;
      end else if (wr_now) begin
         if (addr_q == `RIF_ADDR_DEPTH_CFG) begin
            depth_cfg_q <= wd;
         end else if (addr_q == `RIF_ADDR_SRC_MAP) begin
            src_map_q <= {wd[7:2], 2'h0};
         end else if (addr_q == `RIF_ADDR_LEVEL) begin
            level_q <= wd;
         end else if (addr_q == `RIF_ADDR_STATE) begin
            state_q <= {4'h0, wd[3:0]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flag register: hardware set wins over a software clear
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         flags_q <= `RIF_RST_FLAGS;
         o_restart <= 1'b0;
      end else begin
         o_restart <= 1'b0;
         if (wr_now && addr_q == `RIF_ADDR_FLAGS) begin
            flags_q[`RIF_BIT_FILL_METHOD] <= wd[7];
            flags_q[`RIF_BIT_STR_EN] <= wd[3];
            flags_q[`RIF_BIT_LOCK_EN] <= wd[0];
            if (wd[4]) begin
               flags_q[`RIF_BIT_OVERRUN] <= 1'b0;
               o_restart <= 1'b1;
            end
            if (wd[2]) begin
               flags_q[`RIF_BIT_STR_FLAG] <= 1'b0;
            end
            if (wd[1]) begin
               flags_q[`RIF_BIT_LOCK] <= 1'b0;
            end
            if (wd[7]) begin
               flags_q[`RIF_BIT_FILL] <= wd[6];
            end else if (wd[6] && !flags_q[`RIF_BIT_OVERRUN]) begin
               flags_q[`RIF_BIT_FILL] <= 1'b0;
            end
         end
         // sets come last, so an event in the cycle of a write is kept
         if (i_overrun) begin
            flags_q[`RIF_BIT_OVERRUN] <= 1'b1;
         end
         if (str_event) begin
            flags_q[`RIF_BIT_STR_FLAG] <= 1'b1;
         end
         if (i_pll_lock) begin
            flags_q[`RIF_BIT_LOCK] <= 1'b1;
         end
         if (!flags_q[`RIF_BIT_FILL_METHOD] && i_sync_det) begin
            flags_q[`RIF_BIT_FILL] <= 1'b1;
         end
         // done bit follows shift-out; cleared when transmit ends
         if (i_last_bit_out) begin
            flags_q[`RIF_BIT_TX_DONE] <= 1'b1;
         end else if (radio != rif_pkg::RIF_TX) begin
            flags_q[`RIF_BIT_TX_DONE] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data, registered one edge after the address phase
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rdata_q <= 32'h0;
      end else begin
         rdata_q <= 32'h0;
         if (i_hready && i_hsel && i_htrans[1] && !i_hwrite) begin
            if (i_haddr[ADDR_W-1:0] == `RIF_ADDR_DEPTH_CFG) begin
               rdata_q <= {24'h0, depth_cfg_q};
            end else if (i_haddr[ADDR_W-1:0] == `RIF_ADDR_SRC_MAP) begin
               rdata_q <= {24'h0, src_map_q[7:2], full, not_empty};
            end else if (i_haddr[ADDR_W-1:0] == `RIF_ADDR_FLAGS) begin
               rdata_q <= {24'h0, flags_q};
            end else if (i_haddr[ADDR_W-1:0] == `RIF_ADDR_LEVEL) begin
               rdata_q <= {24'h0, level_q};
            end else if (i_haddr[ADDR_W-1:0] == `RIF_ADDR_STATE) begin
               rdata_q <= {24'h0, state_q};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   depth_sixteen_a: assert property (@(posedge i_clk)
      disable iff (i_rst) depth_cfg_q[7:6] == 2'h0 |-> depth == 7'h10)
      else $error("fifo depth not 16 for code 00");
   depth_max_a: assert property (@(posedge i_clk)
      disable iff (i_rst) depth_cfg_q[7:6] == 2'h3 |-> depth == 7'h40)
      else $error("fifo depth not 64 for code 11");
   thresh_plus_a: assert property (@(posedge i_clk)
      disable iff (i_rst) thresh == {1'b0, depth_cfg_q[5:0]} + 7'h01)
      else $error("threshold not field plus one");
   cont_irq1_a: assert property (@(posedge i_clk)
      disable iff (i_rst)
      mode == rif_pkg::RIF_CONT |-> o_irq1 == i_bit_clock)
      else $error("pin 1 not bit clock in continuous mode");
   buff_none_a: assert property (@(posedge i_clk)
      disable iff (i_rst)
      mode == rif_pkg::RIF_BUFF && radio != rif_pkg::RIF_TX &&
      src_map_q[7:6] == 2'h0 |-> !o_irq0)
      else $error("pin 0 active with no source selected");
   pkt_payload_a: assert property (@(posedge i_clk)
      disable iff (i_rst)
      mode == rif_pkg::RIF_PKT && radio != rif_pkg::RIF_TX &&
      src_map_q[7:6] == 2'h0 |-> o_irq0 == i_payload_ready)
      else $error("pin 0 not payload ready in packet mode");
   tx_start_a: assert property (@(posedge i_clk)
      disable iff (i_rst)
      radio == rif_pkg::RIF_TX && !src_map_q[3] |->
      o_tx_start == (i_fifo_count >= thresh))
      else $error("transmit start not at threshold");
   tx_any_a: assert property (@(posedge i_clk)
      disable iff (i_rst)
      radio == rif_pkg::RIF_TX && src_map_q[3] |->
      o_irq0 == (i_fifo_count != 7'h00))
      else $error("pin 0 not not-empty in transmit");
   tx_irq1_a: assert property (@(posedge i_clk)
      disable iff (i_rst)
      radio == rif_pkg::RIF_TX && mode != rif_pkg::RIF_CONT &&
      src_map_q[2] |-> o_irq1 == flags_q[`RIF_BIT_TX_DONE])
      else $error("pin 1 not transmit done in transmit");
   full_bit_a: assert property (@(posedge i_clk)
      disable iff (i_rst) full == (i_fifo_count >= depth))
      else $error("full flag wrong");
   empty_bit_a: assert property (@(posedge i_clk)
      disable iff (i_rst) i_fifo_count == 7'h00 |-> !not_empty)
      else $error("not-empty bit high with an empty fifo");
   fill_gate_a: assert property (@(posedge i_clk)
      disable iff (i_rst)
      mode == rif_pkg::RIF_BUFF |-> o_fill_en == flags_q[`RIF_BIT_FILL])
      else $error("fill enable not from fill bit in buffered mode");
   fill_auto_a: assert property (@(posedge i_clk)
      disable iff (i_rst)
      !flags_q[`RIF_BIT_FILL_METHOD] && i_sync_det |=>
      flags_q[`RIF_BIT_FILL])
      else $error("fill bit not set on sync");
   fill_manual_a: assert property (@(posedge i_clk)
      disable iff (i_rst)
      wr_now && addr_q == `RIF_ADDR_FLAGS && wd[7] &&
      flags_q[`RIF_BIT_FILL_METHOD] |=>
      flags_q[`RIF_BIT_FILL] == $past(wd[6]))
      else $error("manual fill bit not as written");
   tx_done_a: assert property (@(posedge i_clk)
      disable iff (i_rst) i_last_bit_out |=> flags_q[`RIF_BIT_TX_DONE])
      else $error("transmit done not set");
   overrun_sticky_a: assert property (@(posedge i_clk)
      disable iff (i_rst) i_overrun |=> flags_q[`RIF_BIT_OVERRUN])
      else $error("overrun not captured");
   str_gate_a: assert property (@(posedge i_clk)
      disable iff (i_rst) !flags_q[`RIF_BIT_STR_EN] |-> !str_event)
      else $error("strength source live while disabled");
   str_sticky_a: assert property (@(posedge i_clk)
      disable iff (i_rst) str_event |=> flags_q[`RIF_BIT_STR_FLAG])
      else $error("strength flag not captured");
   lock_sticky_a: assert property (@(posedge i_clk)
      disable iff (i_rst) i_pll_lock |=> flags_q[`RIF_BIT_LOCK])
      else $error("lock flag not captured");
   lock_pin_a: assert property (@(posedge i_clk)
      disable iff (i_rst) !flags_q[`RIF_BIT_LOCK_EN] |-> o_lock_pin)
      else $error("lock pin not high while disabled");
   lock_route_a: assert property (@(posedge i_clk)
      disable iff (i_rst)
      flags_q[`RIF_BIT_LOCK_EN] |-> o_lock_pin == flags_q[`RIF_BIT_LOCK])
      else $error("lock pin not showing lock flag while enabled");
endmodule

// ==== logic/rif_pkg.sv ====
// types shared by the radio irq and fifo flag block
package rif_pkg;
   typedef enum logic [1:0] {
      RIF_CONT, RIF_BUFF, RIF_PKT
   } rif_mode_type;
   typedef enum logic [1:0] {
      RIF_RX, RIF_STBY, RIF_TX
   } rif_radio_type;
   typedef enum logic {
      RIF_IDLE, RIF_DATA
   } rif_bus_type;
endpackage
